// [design/sdc_device.sv]
`timescale 1ns/10ps
module sdc_device
   import sdc_pkg::*;
(
   input wire logic hclk, // Clock
   input wire logic hresetn, // Async reset, low
   input wire logic hsel, // AHB select
   input wire logic [31:0] haddr, // AHB address
   input wire logic [1:0] htrans, // AHB transfer
   input wire logic hwrite, // AHB write
   input wire logic [2:0] hsize, // AHB size
   input wire logic [31:0] hwdata, // AHB write data
   input wire logic hready, // AHB ready in
   output logic [31:0] hrdata, // AHB read data
   output logic hreadyout, // AHB ready out
   output logic hresp, // AHB response
   input wire sdc_strobes_t strobes, // Command strobes
   input wire logic clock_gate, // Clock enable pin
   input wire logic bank_select_0, // Bank bit 0
   input wire logic bank_select_1, // Bank bit 1
   input wire logic [ADDR_W-1:0] addr, // Address pins
   input wire logic byte_mask, // Data mask
   input wire logic [DQ_W-1:0] dq_in, // Data pins in
   output logic [DQ_W-1:0] dq_out, // Data pins out
   output logic dq_oe // Data pins drive
);
   // ----------------------------------------
   // Clock gating
   // ----------------------------------------
   // Sampled clock_gate governs the next edge: one clock of delay
   logic gate_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gate_reg <= 1'b1;
      end else begin
         gate_reg <= clock_gate;
      end
   end
   logic active;
   assign active = gate_reg;

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   sdc_cmd_t cmd;
   always_comb begin
      cmd = SDC_CMD_NOP;
      if (!strobes.chip_select_n) begin
         case ({strobes.row_strobe_n, strobes.column_strobe_n,
                strobes.write_strobe_n})
            3'h7: cmd = SDC_CMD_NOP;
            3'h3: cmd = SDC_CMD_ACT;
            3'h5: cmd = SDC_CMD_READ;
            3'h4: cmd = SDC_CMD_WRITE;
            3'h6: cmd = SDC_CMD_BST;
            3'h2: cmd = SDC_CMD_PRE;
            3'h1: cmd = SDC_CMD_REF;
            3'h0: cmd = SDC_CMD_LMR;
            default: cmd = SDC_CMD_NOP;
         endcase
      end
   end
   logic [1:0] bank;
   assign bank = {bank_select_1, bank_select_0};
   logic ctrl_en_reg;
   logic take;
   assign take = active && ctrl_en_reg;

   // ----------------------------------------
   // Bank rows and mode register
   // ----------------------------------------
   logic [BANKS-1:0] open_reg;
   logic [ROW_W-1:0] row_reg [BANKS];
   logic [MODE_W-1:0] mode_reg;
   logic [1:0] read_latency;
   assign read_latency = (mode_reg[5:4] == 2'h0) ? READ_LATENCY_RST
                                                 : mode_reg[5:4];
   sdc_state_t state_reg;
   logic self_exit;
   assign self_exit = (state_reg == SDC_ST_SELF) && clock_gate;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         open_reg <= '0;
         for (int i = 0; i < BANKS; i++) begin
            row_reg[i] <= '0;
         end
      end else if (take) begin
         if (cmd == SDC_CMD_ACT) begin
            open_reg[bank] <= 1'b1;
            row_reg[bank] <= addr[ROW_W-1:0];
         end else if (cmd == SDC_CMD_PRE) begin
            if (addr[AP_BIT]) begin
               open_reg <= '0;
            end else begin
               open_reg[bank] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_reg <= {6'h00, READ_LATENCY_RST, 1'b0, BURST_LEN_RST};
      end else if (take && cmd == SDC_CMD_LMR) begin
         mode_reg <= addr[MODE_W-1:0];
      end
   end

   // ----------------------------------------
   // Refresh counter and state
   // ----------------------------------------
   logic [ROW_W-1:0] ref_row_reg;
   logic [31:0] ref_count_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= SDC_ST_IDLE;
         ref_row_reg <= '0;
         ref_count_reg <= '0;
      end else begin
         if (take && cmd == SDC_CMD_REF) begin
            // Row comes from internal counter, address ignored
            ref_row_reg <= ref_row_reg + ROW_W'(1);
            ref_count_reg <= ref_count_reg + 32'h1;
         end
         if (take && cmd == SDC_CMD_REF && !clock_gate) begin
            state_reg <= SDC_ST_SELF;
         end else if (self_exit) begin
            state_reg <= SDC_ST_IDLE;
         end else if (take && cmd == SDC_CMD_READ) begin
            state_reg <= SDC_ST_READ;
         end else if (take && cmd == SDC_CMD_WRITE) begin
            state_reg <= SDC_ST_WRITE;
         end else if (take && (cmd == SDC_CMD_BST ||
                               cmd == SDC_CMD_PRE)) begin
            state_reg <= SDC_ST_IDLE;
         end
      end
   end

   // ----------------------------------------
   // Data storage (small window of the array)
   // ----------------------------------------
   // Only a few columns are kept; a full array is out of scope
   logic [DQ_W-1:0] mem_reg [MEM_DEPTH];
   logic [MEM_AW-1:0] wcol;
   assign wcol = addr[MEM_AW-1:0];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < MEM_DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
      end else if (take && cmd == SDC_CMD_WRITE && open_reg[bank]) begin
         // First word with the command; mask drops it at once
         if (!byte_mask) begin
            mem_reg[wcol] <= dq_in;
         end
      end
   end

   // ----------------------------------------
   // Read pipeline
   // ----------------------------------------
   // Stage 0 is the command edge; data leaves read_latency later
   logic [3:0] rd_v_reg;
   logic [DQ_W-1:0] rd_d_reg [4];
   logic [1:0] mask_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_v_reg <= '0;
         for (int i = 0; i < 4; i++) begin
            rd_d_reg[i] <= '0;
         end
      end else if (active) begin
         rd_v_reg[0] <= take && cmd == SDC_CMD_READ && open_reg[bank];
         rd_d_reg[0] <= mem_reg[wcol];
         for (int i = 1; i < 4; i++) begin
            rd_v_reg[i] <= rd_v_reg[i-1];
            rd_d_reg[i] <= rd_d_reg[i-1];
         end
         if (take && (cmd == SDC_CMD_PRE || cmd == SDC_CMD_BST)) begin
            // Stages 0 through read_latency are cut, one past output stage read_latency-1
            rd_v_reg[0] <= 1'b0;
            for (int i = 1; i < 4; i++) begin
               if (i <= int'(read_latency)) begin
                  rd_v_reg[i] <= 1'b0;
               end
            end
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_reg <= '0;
      end else begin
         mask_reg <= {mask_reg[0], byte_mask};
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dq_out <= '0;
         dq_oe <= 1'b0;
      end else begin
         dq_out <= rd_d_reg[read_latency - 2'h1];
         // Mask seen one clock earlier floats the pins
         dq_oe <= rd_v_reg[read_latency - 2'h1] && !mask_reg[0] &&
                  active;
      end
   end

   // ----------------------------------------
   // AHB-Lite slave
   // ----------------------------------------
   logic dph_reg;
   logic dph_wr_reg;
   logic [7:0] dph_ofs_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_reg <= 1'b0;
         dph_wr_reg <= 1'b0;
         dph_ofs_reg <= '0;
      end else if (hready) begin
         dph_reg <= hsel && htrans == HTRANS_NONSEQ;
         dph_wr_reg <= hwrite;
         dph_ofs_reg <= haddr[7:0];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_en_reg <= 1'b1;
      end else if (dph_reg && dph_wr_reg && dph_ofs_reg == OFS_CTRL) begin
         ctrl_en_reg <= hwdata[CTRL_ENABLE_BIT];
      end
   end
   always_comb begin
      hrdata = 32'h0000_0000;
      if (dph_reg && !dph_wr_reg) begin
         case (dph_ofs_reg)
            OFS_CTRL: hrdata = {31'h0, ctrl_en_reg};
            OFS_STATUS: hrdata = {27'h0, gate_reg, dq_oe,
                                  state_reg, 1'b0};
            OFS_MODE: hrdata = {20'h0, mode_reg};
            OFS_ROWS: hrdata = {28'h0, open_reg};
            OFS_REFCNT: hrdata = ref_count_reg;
            default: hrdata = 32'h0000_0000;
         endcase
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_deselect_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
      strobes.chip_select_n |-> cmd == SDC_CMD_NOP)
      else $error("deselected strobes decoded");
   a_act_opens: assert property (@(posedge hclk) disable iff (!hresetn)
      take && cmd == SDC_CMD_ACT |=> open_reg[$past(bank)])
      else $error("activate did not open bank");
   a_pre_all: assert property (@(posedge hclk) disable iff (!hresetn)
      take && cmd == SDC_CMD_PRE && addr[AP_BIT] |=> open_reg == '0)
      else $error("precharge all left bank open");
   a_self_entry: assert property (@(posedge hclk) disable iff (!hresetn)
      take && cmd == SDC_CMD_REF && !clock_gate |=> state_reg == SDC_ST_SELF)
      else $error("self refresh not entered");
   a_mode_load: assert property (@(posedge hclk) disable iff (!hresetn)
      take && cmd == SDC_CMD_LMR |=> mode_reg == $past(addr[MODE_W-1:0]))
      else $error("mode register not loaded");
   a_read_mask: assert property (@(posedge hclk) disable iff (!hresetn)
      byte_mask |-> ##2 !dq_oe)
      else $error("masked read drove pins");
   a_gate_delay: assert property (@(posedge hclk) disable iff (!hresetn)
      1'b1 |=> gate_reg == $past(clock_gate))
      else $error("clock gate delay wrong");
   // Output register adds a clock, so the float lands two edges on
   a_pre_float: assert property (@(posedge hclk) disable iff (!hresetn)
      take && cmd == SDC_CMD_PRE |-> ##2 !dq_oe)
      else $error("read not floated after precharge");
   c_read: cover property (@(posedge hclk) dq_oe);
   c_self: cover property (@(posedge hclk) state_reg == SDC_ST_SELF);
   c_write: cover property (@(posedge hclk) take && cmd == SDC_CMD_WRITE);
   c_masked_write: cover property (@(posedge hclk) take &&
      cmd == SDC_CMD_WRITE && byte_mask);
   c_burst_stop: cover property (@(posedge hclk) take && cmd == SDC_CMD_BST);

   // ----------------------------------------
   // Storage, read, deselect, precharge, refresh, burst and gating checks
   // ----------------------------------------
   a_write_lands: assert property (@(posedge hclk)
      disable iff (!hresetn) take && cmd == SDC_CMD_WRITE &&
      open_reg[bank] && !byte_mask |=> mem_reg[$past(wcol)] == $past(dq_in))
      else $error("write word not stored");
   a_write_masked: assert property (@(posedge hclk)
      disable iff (!hresetn) take && cmd == SDC_CMD_WRITE && byte_mask
      |=> mem_reg[$past(wcol)] == $past(mem_reg[wcol]))
      else $error("masked write changed storage");
   a_read_capture: assert property (@(posedge hclk)
      disable iff (!hresetn) take && cmd == SDC_CMD_READ && open_reg[bank]
      |=> rd_v_reg[0] && rd_d_reg[0] == $past(mem_reg[wcol]))
      else $error("read did not capture column");
   a_inhibit_holds: assert property (@(posedge hclk)
      disable iff (!hresetn) strobes.chip_select_n
      |=> open_reg == $past(open_reg) && mode_reg == $past(mode_reg))
      else $error("deselected cycle changed state");
   a_gate_freeze: assert property (@(posedge hclk)
      disable iff (!hresetn) !active
      |=> open_reg == $past(open_reg) && mode_reg == $past(mode_reg))
      else $error("suspended clock changed state");
   a_pre_one: assert property (@(posedge hclk)
      disable iff (!hresetn) take && cmd == SDC_CMD_PRE && !addr[AP_BIT]
      |=> !open_reg[$past(bank)])
      else $error("precharge left bank open");
   a_refresh_row: assert property (@(posedge hclk)
      disable iff (!hresetn) take && cmd == SDC_CMD_REF
      |=> ref_row_reg == $past(ref_row_reg) + ROW_W'(1))
      else $error("refresh row counter stalled");
   a_auto_refresh: assert property (@(posedge hclk)
      disable iff (!hresetn) take && cmd == SDC_CMD_REF && clock_gate
      |=> state_reg != SDC_ST_SELF)
      else $error("auto refresh entered self refresh");
   a_self_hold: assert property (@(posedge hclk)
      disable iff (!hresetn) state_reg == SDC_ST_SELF && !clock_gate
      |=> state_reg == SDC_ST_SELF)
      else $error("self refresh left while gated");
   a_bst_cut: assert property (@(posedge hclk)
      disable iff (!hresetn) take && cmd == SDC_CMD_BST
      |=> !rd_v_reg[0] && state_reg == SDC_ST_IDLE)
      else $error("burst terminate did not stop burst");
endmodule // sdc_device

// [design/sdc_pkg.sv]
package sdc_pkg;
   // ----------------------------------------
   // Geometry
   // ----------------------------------------
   localparam int ROW_W = 13;
   localparam int COL_W = 10;
   localparam int MODE_W = 12;
   localparam int DQ_W = 8;
   localparam int BANKS = 4;
   localparam int MEM_DEPTH = 16;
   localparam int MEM_AW = 4;
   localparam int ADDR_W = 13;
   localparam int AP_BIT = 10;
   // ----------------------------------------
   // Latencies in clocks
   // ----------------------------------------
   localparam int READ_MASK_LATENCY = 2;
   localparam int WRITE_MASK_LATENCY = 0;
   localparam int WRITE_DATA_DELAY = 0;
   localparam int CLOCK_GATE_ENTRY_DELAY = 1;
   localparam logic [1:0] READ_LATENCY_RST = 2'h3;
   localparam logic [2:0] BURST_LEN_RST = 3'h0;
   // ----------------------------------------
   // AHB register map
   // ----------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_MODE = 8'h08;
   localparam logic [7:0] OFS_ROWS = 8'h0C;
   localparam logic [7:0] OFS_REFCNT = 8'h10;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef enum logic [2:0] {
      SDC_CMD_NOP = 3'h0,
      SDC_CMD_ACT = 3'h1,
      SDC_CMD_READ = 3'h2,
      SDC_CMD_WRITE = 3'h3,
      SDC_CMD_BST = 3'h4,
      SDC_CMD_PRE = 3'h5,
      SDC_CMD_REF = 3'h6,
      SDC_CMD_LMR = 3'h7
   } sdc_cmd_t;

   typedef enum logic [1:0] {
      SDC_ST_IDLE = 2'h0,
      SDC_ST_READ = 2'h1,
      SDC_ST_WRITE = 2'h2,
      SDC_ST_SELF = 2'h3
   } sdc_state_t;

   typedef struct packed {
      logic chip_select_n;
      logic row_strobe_n;
      logic column_strobe_n;
      logic write_strobe_n;
   } sdc_strobes_t;
endpackage

// [dv/sdc_ctrl_model.sv]
`timescale 1ns/10ps
module sdc_ctrl_model
   import sdc_pkg::*;
(
   input wire logic hclk, // Clock
   output sdc_strobes_t strobes, // Command strobes
   output logic clock_gate, // Clock enable pin
   output logic bank_select_1, // Bank bit 1
   output logic bank_select_0, // Bank bit 0
   output logic [ADDR_W-1:0] addr, // Address pins
   output logic byte_mask, // Data mask
   output logic [DQ_W-1:0] dq // Write data
);
   // ----------------------------------------
   // Gaps in clocks at 100 ns, rounded up
   // ----------------------------------------
   localparam int MODE_GAP = 2;
   localparam int WR_TO_PRE = 2;
   localparam int AP_WR_TO_ACT = 5;
   localparam int SELF_EXIT = 2;
   localparam int ROW_TO_COL = 1;
   // Runs are far shorter than the refresh window
   localparam int REFRESHES = 8192;
   initial begin
      strobes = 4'hF;
      clock_gate = 1'b1;
      {bank_select_1, bank_select_0} = 2'h0;
      addr = '0;
      byte_mask = 1'b0;
      dq = 8'h00;
   end
   function automatic sdc_strobes_t enc(input sdc_cmd_t c);
      case (c)
         SDC_CMD_ACT: enc = 4'h3;
         SDC_CMD_READ: enc = 4'h5;
         SDC_CMD_WRITE: enc = 4'h4;
         SDC_CMD_BST: enc = 4'h6;
         SDC_CMD_PRE: enc = 4'h2;
         SDC_CMD_REF: enc = 4'h1;
         SDC_CMD_LMR: enc = 4'h0;
         default: enc = 4'h7;
      endcase
   endfunction
   // Back-to-back calls give a new column every clock
   task automatic cmd(input sdc_cmd_t c, input logic [1:0] ba,
         input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic m);
      @(posedge hclk);
      strobes <= enc(c);
      {bank_select_1, bank_select_0} <= ba;
      addr <= a;
      byte_mask <= m;
      // Idle data lines toggle so stale words never look valid
      dq <= (c == SDC_CMD_WRITE) ? d : ~dq;
   endtask
   task automatic nop(input int n, input logic m);
      repeat (n) cmd(SDC_CMD_NOP, 2'h0, ~addr, 8'h00, m);
   endtask
   task automatic inhibit();
      @(posedge hclk);
      strobes <= 4'hC;
      byte_mask <= 1'b0;
      dq <= ~dq;
   endtask
   task automatic gate(input logic v);
      clock_gate <= v;
   endtask
   task automatic powerup();
      nop(4, 1'b0);
      cmd(SDC_CMD_REF, 2'h0, 13'h0, 8'h00, 1'b0);
      nop(1, 1'b0);
      cmd(SDC_CMD_REF, 2'h0, 13'h0, 8'h00, 1'b0);
      nop(1, 1'b0);
   endtask
endmodule // sdc_ctrl_model

// [dv/sdc_device_tb.sv]
`timescale 1ns/10ps
module sdc_device_tb;
   import sdc_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic [31:0] hrdata, rd;
   logic hready, hresp, clock_gate, bs0, bs1, byte_mask, dq_oe;
   sdc_strobes_t strobes;
   logic [ADDR_W-1:0] addr;
   logic [DQ_W-1:0] dq_in, dq_out;
   logic [7:0] mem [16];
   logic [7:0] exp_d [$];
   realtime exp_t [$];
   int num_errors = 0, checked = 0, cycles = 0, lat = 3, seed = 43, d;
   // Fixed rate throughout accesses
   always #50 hclk = ~hclk;
   sdc_ctrl_model ctl (.hclk(hclk), .strobes(strobes),
      .clock_gate(clock_gate), .bank_select_1(bs1), .bank_select_0(bs0),
      .addr(addr), .byte_mask(byte_mask), .dq(dq_in));
   sdc_device uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .strobes(strobes),
      .clock_gate(clock_gate), .bank_select_0(bs0), .bank_select_1(bs1),
      .addr(addr), .byte_mask(byte_mask), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      if (num_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic ahb(input logic w, input logic [7:0] a,
         input logic [31:0] wd, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input int c, input logic [7:0] v, input logic m);
      ctl.cmd(SDC_CMD_WRITE, 2'h1, ADDR_W'(c), v, m);
      if (!m)
         mem[c] = v;
   endtask
   task automatic rdc(input int c);
      ctl.cmd(SDC_CMD_READ, 2'h1, ADDR_W'(c), 8'h00, 1'b0);
      exp_d.push_back(mem[c]);
      exp_t.push_back($realtime);
   endtask
   // ----------------------------------------
   // Read data watcher
   // ----------------------------------------
   always @(posedge hclk) begin
      if (dq_oe === 1'b1) begin
         if (exp_d.size() == 0) begin
            chk(32'h1, 32'h0);
         end else begin
            chk(dq_out, exp_d.pop_front());
            d = int'(($realtime - exp_t.pop_front()) / 100.0) - 1;
            chk(d == lat || d == lat + 1, 1'b1);
         end
      end
   end
   always @(posedge hclk) begin
      cycles++;
      if (cycles > 2000) begin
         num_errors++;
         final_report();
      end
   end
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, OFS_CTRL, 0, rd);
      chk(rd, 32'h1);
      chk(hresp, 32'h0);
      ahb(1'b0, 8'h40, 0, rd);
      chk(rd, 32'h0);
      ctl.powerup();
      ahb(1'b0, OFS_REFCNT, 0, rd);
      chk(rd, 32'h2);
      ctl.cmd(SDC_CMD_LMR, 2'h3, 13'h1020, 8'h00, 1'b0);
      lat = 2;
      ctl.nop(2, 1'b0);
      ahb(1'b0, OFS_MODE, 0, rd);
      chk(rd, 32'h020);
      ctl.cmd(SDC_CMD_ACT, 2'h1, 13'($random(seed)), 8'h00, 1'b0);
      ahb(1'b0, OFS_ROWS, 0, rd);
      chk(rd, 32'h2);
      for (int i = 0; i < 4; i++)
         wr(i, 8'($random(seed)), 1'b0);
      wr(3, 8'($random(seed)), 1'b1);
      ctl.inhibit();
      wr(1, 8'($random(seed)), 1'b0);
      ctl.gate(1'b0);
      ctl.cmd(SDC_CMD_WRITE, 2'h1, 13'h2, 8'h3C, 1'b0);
      ctl.gate(1'b1);
      ctl.nop(1, 1'b0);
      ahb(1'b1, OFS_CTRL, 32'h0, rd);
      ctl.cmd(SDC_CMD_WRITE, 2'h1, 13'h0, 8'hEE, 1'b0);
      // Strobes persist, so leave the write before enabling again
      ctl.nop(1, 1'b0);
      ahb(1'b1, OFS_CTRL, 32'h1, rd);
      for (int i = 0; i < 4; i++)
         rdc(i);
      ctl.nop(4, 1'b0);
      ctl.cmd(SDC_CMD_READ, 2'h1, 13'h2, 8'h00, 1'b0);
      ctl.cmd(SDC_CMD_BST, 2'h1, 13'h0, 8'h00, 1'b0);
      ctl.nop(4, 1'b0);
      ctl.cmd(SDC_CMD_READ, 2'h1, 13'h1, 8'h00, 1'b1);
      ctl.nop(4, 1'b1);
      ctl.cmd(SDC_CMD_ACT, 2'h0, 13'h0, 8'h00, 1'b0);
      ctl.cmd(SDC_CMD_ACT, 2'h2, 13'h0, 8'h00, 1'b0);
      ctl.cmd(SDC_CMD_PRE, 2'h1, 13'h0, 8'h00, 1'b0);
      ahb(1'b0, OFS_ROWS, 0, rd);
      chk(rd, 32'h5);
      ctl.cmd(SDC_CMD_PRE, 2'h1, 13'h0400, 8'h00, 1'b0);
      ahb(1'b0, OFS_ROWS, 0, rd);
      chk(rd, 32'h0);
      ctl.cmd(SDC_CMD_REF, 2'h0, 13'h0, 8'h00, 1'b0);
      ctl.gate(1'b0);
      ahb(1'b0, OFS_STATUS, 0, rd);
      chk(rd[2:1], SDC_ST_SELF);
      ctl.gate(1'b1);
      ctl.nop(2, 1'b0);
      ctl.nop(6, 1'b0);
      chk(exp_d.size(), 32'h0);
      final_report();
   end
endmodule // sdc_device_tb
